//--- core/adc_lvds_output_control.sv
`timescale 1ns/10ps
// How it works
// [RULE1] each rising encode edge captures the held analog value and starts one conversion.
// [RULE2] the receiver may instead latch the output word on the rising encode edge.
// [RULE3] with power-down low the block converts, with it high it stops and floats all outputs.
// [RULE4] internal dither runs only while the dither enable pin is high.
// [RULE5] each sample leaves as a 16-bit parallel word on pairs 0..15, bit 15 the most significant.
// [RULE6] the receiver registers word and flag on the rising edge of the forwarded clock.
// [RULE7] the range flag is high alongside any sample that went past full scale either way.
// [RULE8] the output mode strap decodes 0V, 1/3, 2/3 and full supply to four output modes.
// [RULE9] the format strap decodes to offset binary or two's complement and stabiliser on or off.
// [RULE10] with scrambling on, bits 1..15 leave XORed with bit 0 and bit 0 leaves unchanged.
// [RULE11] the receiver undoes scrambling by XORing bits 1..15 with the received bit 0.
// [RULE12] a sample reaches the outputs seven encode edges after the edge that captured it.
// [RULE13] the two's complement word is the offset binary word with its top bit inverted.
// [RULE14] scrambling acts on the word after number-format conversion.
module adc_lvds_output_control
    import adc_ctrl_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    output logic                     irq,
    input  wire logic                encodeClockPos,
    input  wire logic                encodeClockNeg,
    input  wire logic [SAMPLE_W-1:0] analogSample,
    input  wire logic                analogOverRange,
    input  wire logic                powerDownPin,
    input  wire logic                ditherEnablePin,
    input  wire logic                outputScramblePin,
    input  wire logic [1:0]          outputModeStrap,
    input  wire logic [1:0]          formatStrap,
    output logic [SAMPLE_W-1:0]      sampleBitsPos,
    output logic [SAMPLE_W-1:0]      sampleBitsNeg,
    output logic                     rangeExceededPos,
    output logic                     rangeExceededNeg,
    output logic                     forwardedValidClockPos,
    output logic                     forwardedValidClockNeg,
    output logic                     outputDriveOe_n
);

    // ----------------------------------------
    // strap decoding
    // ----------------------------------------
    function automatic out_mode_t decodeMode(input logic [1:0] lvl);
        out_mode_t m;
        m = MODE_LVDS_STD;
        if (lvl == LEVEL_0V) begin
            m = MODE_CMOS_FULL;
        end else if (lvl == LEVEL_THIRD) begin
            m = MODE_CMOS_DEMUX;
        end else if (lvl == LEVEL_TWO_THIRDS) begin
            m = MODE_LVDS_LOW;
        end
        return m;
    endfunction

    function automatic fmt_t decodeFmt(input logic [1:0] lvl);
        fmt_t f;
        f.twos = lvl[1];
        f.stab = (lvl == LEVEL_THIRD) || (lvl == LEVEL_TWO_THIRDS);
        return f;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pins_t pinsS1_q, pinsS1_d, pinsS2_q, pinsS2_d;
    logic  encLevel_q, encLevel_d;

    // the front end holds its value for a whole encode period, so a
    // plain two-stage sync of the word is coherent by the time it is used
    always_comb begin
        pinsS1_d = '{encPos: encodeClockPos, encNeg: encodeClockNeg,
                     powerDown: powerDownPin, dither: ditherEnablePin,
                     scramble: outputScramblePin, modeStrap: outputModeStrap,
                     fmtStrap: formatStrap,
                     analog: '{over: analogOverRange, word: analogSample}};
        pinsS2_d = pinsS1_q;
        encLevel_d = pinsS2_q.encPos & ~pinsS2_q.encNeg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinsS1_q   <= '0;
            pinsS2_q   <= '0;
            encLevel_q <= 1'b0;
        end else begin
            pinsS1_q   <= pinsS1_d;
            pinsS2_q   <= pinsS2_d;
            encLevel_q <= encLevel_d;
        end
    end

    // ----------------------------------------
    // conversion pipeline
    // ----------------------------------------
    out_mode_t outMode;
    fmt_t      fmt;
    logic      encRise, encFall, advance, lvdsMode;

    // encode is high when the positive leg is above the negative one
    assign encRise  = encLevel_d & ~encLevel_q;
    assign encFall  = ~encLevel_d & encLevel_q;
    // [RULE8] mode strap decode
    assign outMode  = decodeMode(pinsS2_q.modeStrap);
    // [RULE9] format strap decode
    assign fmt      = decodeFmt(pinsS2_q.fmtStrap);
    assign lvdsMode = (outMode == MODE_LVDS_LOW) || (outMode == MODE_LVDS_STD);
    // [RULE3] no conversions while powered down
    assign advance  = encRise & ~pinsS2_q.powerDown;

    sample_t             pipe_q [LATENCY];
    sample_t             pipe_d [LATENCY];
    logic [SAMPLE_W-1:0] lfsr_q, lfsr_d;
    logic [31:0]         count_q, count_d;

    always_comb begin
        for (int i = 0; i < LATENCY; i++) begin
            pipe_d[i] = pipe_q[i];
        end
        lfsr_d  = lfsr_q;
        count_d = count_q;
        if (advance) begin
            // [RULE1] capture on encode rise
            pipe_d[0] = pinsS2_q.analog;
            // [RULE12] seven-edge delay line
            for (int i = 1; i < LATENCY; i++) begin
                pipe_d[i] = pipe_q[i-1];
            end
            count_d = count_q + 32'h1;
            // [RULE4] dither runs only when enabled
            if (pinsS2_q.dither) begin
                lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_q[i] <= '0;
            end
            lfsr_q  <= DITHER_SEED;
            count_q <= COUNT_RESET;
        end else begin
            pipe_q  <= pipe_d;
            lfsr_q  <= lfsr_d;
            count_q <= count_d;
        end
    end

    // ----------------------------------------
    // output formatting and drivers
    // ----------------------------------------
    logic [SAMPLE_W-1:0] fmtWord, outWord_d, outWord_q, outWordN_q;
    logic                outOver_d, outOver_q, outOverN_q;
    logic                fwdClk_d, fwdClk_q, fwdClkN_q, oeN_d, oeN_q;

    always_comb begin
        fmtWord = pipe_q[LATENCY-1].word;
        // [RULE13] two's complement by msb flip
        if (fmt.twos) begin
            fmtWord[SAMPLE_W-1] = ~fmtWord[SAMPLE_W-1];
        end
        outWord_d = outWord_q;
        outOver_d = outOver_q;
        fwdClk_d  = fwdClk_q;
        if (advance) begin
            // [RULE14] scramble the formatted word
            // [RULE10] upper bits XOR bit zero
            outWord_d = pinsS2_q.scramble
                      ? {fmtWord[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){fmtWord[0]}}, fmtWord[0]}
                      : fmtWord;
            // [RULE7] flag travels with its sample
            outOver_d = pipe_q[LATENCY-1].over;
            // new word goes out with the forwarded clock low
            fwdClk_d  = 1'b0;
        end else if (encFall && !pinsS2_q.powerDown) begin
            // [RULE6] rising forwarded edge mid-word
            fwdClk_d  = 1'b1;
        end
        // [RULE3] float outputs in power-down
        oeN_d = pinsS2_q.powerDown | ~lvdsMode;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            outWord_q  <= '0;
            outWordN_q <= '1;
            outOver_q  <= 1'b0;
            outOverN_q <= 1'b1;
            fwdClk_q   <= 1'b0;
            fwdClkN_q  <= 1'b1;
            oeN_q      <= 1'b1;
        end else begin
            outWord_q  <= outWord_d;
            outWordN_q <= ~outWord_d;
            outOver_q  <= outOver_d;
            outOverN_q <= ~outOver_d;
            fwdClk_q   <= fwdClk_d;
            fwdClkN_q  <= ~fwdClk_d;
            oeN_q      <= oeN_d;
        end
    end

    // [RULE5] pair 15 carries the msb
    assign sampleBitsPos          = outWord_q;
    assign sampleBitsNeg          = outWordN_q;
    assign rangeExceededPos       = outOver_q;
    assign rangeExceededNeg       = outOverN_q;
    assign forwardedValidClockPos = fwdClk_q;
    assign forwardedValidClockNeg = fwdClkN_q;
    assign outputDriveOe_n        = oeN_q;

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    logic [IRQ_W-1:0] status_q, status_d, enable_q, enable_d, events, clearMask;
    logic             pdPrev_q, irq_q, irq_d;
    logic [3:0]       strapPrev_q;
    logic             wrPend_q, wrPend_d;
    logic [7:0]       wrAddr_q, wrAddr_d;

    always_comb begin
        events            = '0;
        events[IRQ_OVER]  = advance & pipe_q[LATENCY-1].over;
        events[IRQ_WAKE]  = pdPrev_q & ~pinsS2_q.powerDown;
        events[IRQ_STRAP] = strapPrev_q != {pinsS2_q.modeStrap, pinsS2_q.fmtStrap};
        clearMask = '0;
        enable_d  = enable_q;
        if (wrPend_q && wrAddr_q == ADDR_IRQ_CLEAR) begin
            clearMask = hwdata[IRQ_W-1:0];
        end else if (wrPend_q && wrAddr_q == ADDR_IRQ_ENABLE) begin
            enable_d = hwdata[IRQ_W-1:0];
        end
        // an event in the clearing cycle survives
        status_d = (status_q & ~clearMask) | events;
        irq_d    = |(status_d & enable_d);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_q    <= IRQ_RESET;
            enable_q    <= IRQ_RESET;
            irq_q       <= 1'b0;
            pdPrev_q    <= 1'b0;
            strapPrev_q <= '0;
        end else begin
            status_q    <= status_d;
            enable_q    <= enable_d;
            irq_q       <= irq_d;
            pdPrev_q    <= pinsS2_q.powerDown;
            strapPrev_q <= {pinsS2_q.modeStrap, pinsS2_q.fmtStrap};
        end
    end

    assign irq = irq_q;

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    logic        addrPhase;
    logic [31:0] rdata_d, rdata_q, stateWord;

    assign addrPhase = hsel & htrans[1] & hready;

    always_comb begin
        stateWord                   = '0;
        stateWord[ST_MODE+:4]       = outMode;
        stateWord[ST_TWOS]          = fmt.twos;
        stateWord[ST_STAB]          = fmt.stab;
        stateWord[ST_DITHER_ENABLE_PIN]          = pinsS2_q.dither;
        stateWord[ST_SCR]           = pinsS2_q.scramble;
        stateWord[ST_PD]            = pinsS2_q.powerDown;
        stateWord[ST_LFSR+:16]      = lfsr_q;
        wrPend_d = addrPhase & hwrite;
        wrAddr_d = haddr[7:0];
        rdata_d  = '0;
        // unmapped and write-only offsets read as zero
        if (addrPhase && !hwrite) begin
            if (haddr[7:0] == ADDR_IRQ_STATUS) begin
                rdata_d[IRQ_W-1:0] = status_q;
            end else if (haddr[7:0] == ADDR_IRQ_ENABLE) begin
                rdata_d[IRQ_W-1:0] = enable_q;
            end else if (haddr[7:0] == ADDR_STATE) begin
                rdata_d = stateWord;
            end else if (haddr[7:0] == ADDR_LAST_SAMPLE) begin
                rdata_d = {15'h0, outOver_q, outWord_q};
            end else if (haddr[7:0] == ADDR_SAMPLE_COUNT) begin
                rdata_d = count_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPend_q  <= 1'b0;
            wrAddr_q  <= '0;
            rdata_q   <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_q  <= wrPend_d;
            wrAddr_q  <= wrAddr_d;
            rdata_q   <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_capture_on_rise: assert property (advance |=> pipe_q[0] == $past(pinsS2_q.analog)) // [RULE1]
        else $error("capture missed the encode rise");
    a_shutdown_floats: assert property (pinsS2_q.powerDown |=> outputDriveOe_n) // [RULE3]
        else $error("outputs driven in power-down");
    a_dither_frozen: assert property (advance && !pinsS2_q.dither |=> $stable(lfsr_q)) // [RULE4]
        else $error("dither ran while disabled");
    a_word_order_msb: assert property ( // [RULE5]
        advance && !fmt.twos && !pinsS2_q.scramble |=>
            sampleBitsPos == $past(pipe_q[LATENCY-1].word) && sampleBitsNeg == ~sampleBitsPos)
        else $error("word order or pair polarity wrong");
    a_flag_with_sample: assert property ( // [RULE7]
        advance |=> rangeExceededPos == $past(pipe_q[LATENCY-1].over))
        else $error("range flag not with its sample");
    a_mode_decode: assert property ( // [RULE8]
        pinsS2_q.modeStrap == LEVEL_TWO_THIRDS |-> outMode == MODE_LVDS_LOW)
        else $error("mode strap decoded wrongly");
    a_format_decode: assert property ( // [RULE9]
        pinsS2_q.fmtStrap == LEVEL_FULL |-> fmt.twos && !fmt.stab)
        else $error("format strap decoded wrongly");
    a_scramble_xor: assert property ( // [RULE10]
        advance && pinsS2_q.scramble |=>
            (sampleBitsPos ^ {{(SAMPLE_W-1){sampleBitsPos[0]}}, 1'b0}) == $past(fmtWord))
        else $error("scrambled word does not decode");
    a_latency_shift: assert property ( // [RULE12]
        advance |=> pipe_q[LATENCY-1] == $past(pipe_q[LATENCY-2]))
        else $error("delay line did not shift");
    a_twos_msb_flip: assert property ( // [RULE13]
        advance && fmt.twos && !pinsS2_q.scramble |=>
            sampleBitsPos[SAMPLE_W-1] == ~$past(pipe_q[LATENCY-1].word[SAMPLE_W-1]))
        else $error("two's complement msb not inverted");
    a_irq_level: assert property (irq == |(status_q & enable_q))
        else $error("interrupt does not follow status and enable");

    c_scrambled_sample: cover property (advance && pinsS2_q.scramble);
    c_power_down_wake:  cover property (pinsS2_q.powerDown ##1 !pinsS2_q.powerDown);
    c_overrange_irq:    cover property (events[IRQ_OVER] ##1 irq);
    c_twos_sample:      cover property (advance && fmt.twos);

endmodule

//--- core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ----------------------------------------
    // data path
    // ----------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int LATENCY  = 7;
    localparam int IRQ_W    = 3;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_IRQ_CLEAR    = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h08;
    localparam logic [7:0] ADDR_STATE        = 8'h0c;
    localparam logic [7:0] ADDR_LAST_SAMPLE  = 8'h10;
    localparam logic [7:0] ADDR_SAMPLE_COUNT = 8'h14;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int IRQ_OVER  = 0;
    localparam int IRQ_WAKE  = 1;
    localparam int IRQ_STRAP = 2;
    localparam int ST_MODE   = 0;
    localparam int ST_TWOS   = 4;
    localparam int ST_STAB   = 5;
    localparam int ST_DITHER_ENABLE_PIN   = 6;
    localparam int ST_SCR    = 7;
    localparam int ST_PD     = 8;
    localparam int ST_LFSR   = 16;
    localparam logic [IRQ_W-1:0]    IRQ_RESET   = 3'h0;
    localparam logic [SAMPLE_W-1:0] DITHER_SEED = 16'hace1;
    localparam logic [31:0]         COUNT_RESET = 32'h0;

    // four-level strap codes, as delivered by the level detectors
    localparam logic [1:0] LEVEL_0V         = 2'h0;
    localparam logic [1:0] LEVEL_THIRD      = 2'h1;
    localparam logic [1:0] LEVEL_TWO_THIRDS = 2'h2;
    localparam logic [1:0] LEVEL_FULL       = 2'h3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        MODE_CMOS_FULL  = 4'b0001,
        MODE_CMOS_DEMUX = 4'b0010,
        MODE_LVDS_LOW   = 4'b0100,
        MODE_LVDS_STD   = 4'b1000
    } out_mode_t;

    typedef struct packed {
        logic twos;
        logic stab;
    } fmt_t;

    typedef struct packed {
        logic                over;
        logic [SAMPLE_W-1:0] word;
    } sample_t;

    typedef struct packed {
        logic    encPos;
        logic    encNeg;
        logic    powerDown;
        logic    dither;
        logic    scramble;
        logic [1:0] modeStrap;
        logic [1:0] fmtStrap;
        sample_t analog;
    } pins_t;

endpackage

//--- test/lvds_capture_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// downstream receiver of the output link
// ----------------------------------------
module lvds_capture_model
    import adc_ctrl_pkg::*;
(
    input  wire logic                forwardedValidClockPos,
    input  wire logic                forwardedValidClockNeg,
    input  wire logic [SAMPLE_W-1:0] sampleBitsPos,
    input  wire logic [SAMPLE_W-1:0] sampleBitsNeg,
    input  wire logic                rangeExceededPos,
    input  wire logic                rangeExceededNeg,
    input  wire logic                outputDriveOe_n,
    input  wire logic                outputScramblePin,
    output sample_t                  rxSample,
    output int                       rxCount,
    output int                       legErrors
);
    initial begin
        rxCount = 0;
        legErrors = 0;
    end

    // latch on forwarded rise
    // encode-edge capture is the other option; forwarded clock chosen since it tracks data skew
    always @(posedge forwardedValidClockPos) begin
        // the negative leg updates in the same step, let it settle
        #1;
        if (outputDriveOe_n === 1'b0) begin
            // legs of every pair must be complements, else the receiver sees garbage
            if (sampleBitsNeg !== ~sampleBitsPos || rangeExceededNeg !== ~rangeExceededPos
                || forwardedValidClockNeg !== 1'b0) begin
                legErrors <= legErrors + 1;
            end
            rxSample.over <= rangeExceededPos;
            rxSample.word <= outputScramblePin ?
                {sampleBitsPos[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){sampleBitsPos[0]}}, sampleBitsPos[0]}
                : sampleBitsPos;
            rxCount <= rxCount + 1;
        end
    end
endmodule

//--- test/adc_lvds_output_control_test.sv
`timescale 1ns/10ps
module adc_lvds_output_control_test import adc_ctrl_pkg::*;;
    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    logic                hsel = 1'b0;
    logic                hwrite = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [31:0]         hwdata = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic [2:0]          hsize = 3'h2;
    logic [1:0]          outputModeStrap = 2'h3;
    logic [1:0]          formatStrap = 2'h0;
    logic                powerDownPin = 1'b0;
    logic                ditherEnablePin = 1'b0;
    logic                outputScramblePin = 1'b0;
    logic                encodeClockPos = 1'b0;
    wire logic           encodeClockNeg;
    logic [SAMPLE_W-1:0] analogSample;
    logic                analogOverRange;
    logic                hreadyout, hresp, irq, outputDriveOe_n;
    logic [31:0]         hrdata, rd, lfsrA;
    logic [SAMPLE_W-1:0] sampleBitsPos, sampleBitsNeg;
    logic                rangeExceededPos, rangeExceededNeg;
    logic                forwardedValidClockPos, forwardedValidClockNeg;
    logic                encRun = 1'b0, streamCheck = 1'b0, twosNow = 1'b0;
    sample_t             rxSample, exp;
    int                  rxCount, legErrors, c;
    int                  failCount = 0, checks = 0, encCount = 0, runBase = 0, cycles = 0;

    assign encodeClockNeg = ~encodeClockPos;

    adc_lvds_output_control i_dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq, .encodeClockPos,
        .encodeClockNeg, .analogSample, .analogOverRange, .powerDownPin, .ditherEnablePin,
        .outputScramblePin, .outputModeStrap, .formatStrap, .sampleBitsPos, .sampleBitsNeg,
        .rangeExceededPos, .rangeExceededNeg, .forwardedValidClockPos,
        .forwardedValidClockNeg, .outputDriveOe_n);

    lvds_capture_model i_rx (.forwardedValidClockPos, .forwardedValidClockNeg, .sampleBitsPos,
        .sampleBitsNeg, .rangeExceededPos, .rangeExceededNeg, .outputDriveOe_n,
        .outputScramblePin, .rxSample, .rxCount, .legErrors);

    // ----------------------------------------
    // clocks and helpers
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;

    // encode link, 125 ns, halts low between streams; new input on each fall
    always begin
        #62.5;
        // every other toggle meets a sys_clk edge, so drive like a flop
        if (encRun || encodeClockPos) begin
            encodeClockPos <= ~encodeClockPos;
            if (!encodeClockPos)
                encCount++;
            else
                {analogOverRange, analogSample} <= srcOf(encCount + 1);
        end
    end

    // hang guard, about twenty times the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            report_and_stop();
        end
    end

    function automatic sample_t srcOf(int k);
        sample_t s;
        s.word = 16'h9e37 * k[15:0] + 16'h0101;
        s.over = (k % 3 == 0);
        return s;
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic waitCycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one single AHB-Lite transfer; read data taken at data-phase end
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(n, e, rd & m);
    endtask

    // stream n samples; outputs older than the run are skipped
    task automatic runStream(input logic [1:0] mode, input logic [1:0] fmt, input logic scr,
                             input logic dither_enable_pin, input int n);
        int c0;
        outputModeStrap <= mode;
        formatStrap <= fmt;
        outputScramblePin <= scr;
        ditherEnablePin <= dither_enable_pin;
        twosNow = fmt[1];
        waitCycles(8);
        ahb(1'b0, ADDR_STATE, 32'h0);
        lfsrA = rd;
        c0 = rxCount;
        runBase = encCount;
        streamCheck = 1'b1;
        encRun = 1'b1;
        wait (encCount == runBase + n);
        encRun = 1'b0;
        waitCycles(20);
        streamCheck = 1'b0;
        chk("rx count", n, rxCount - c0);
        ahb(1'b0, ADDR_STATE, 32'h0);
        chk("dither step", dither_enable_pin, rd[31:16] != lfsrA[31:16]);
    endtask

    // word seen by the receiver against the sample taken seven rises earlier
    always @(posedge forwardedValidClockPos) begin
        #2;
        if (streamCheck && encCount - runBase >= 8) begin
            exp = srcOf(encCount - 7);
            exp.word[SAMPLE_W-1] = exp.word[SAMPLE_W-1] ^ twosNow;
            chk("rx word", exp.word, rxSample.word);
            chk("rx over", exp.over, rxSample.over);
        end
    end

    // latching on the encode rise sees the previous conversion
    always @(posedge encodeClockPos) begin
        #1;
        if (streamCheck && encCount - runBase >= 9) begin
            exp = srcOf(encCount - 8);
            exp.word[SAMPLE_W-1] = exp.word[SAMPLE_W-1] ^ twosNow;
            if (outputScramblePin)
                exp.word[SAMPLE_W-1:1] = exp.word[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){exp.word[0]}};
            chk("enc word", exp.word, sampleBitsPos);
        end
    end

    task automatic report_and_stop();
        if (failCount == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {analogOverRange, analogSample} = srcOf(1);
        waitCycles(20);
        chk("oe_n in reset", 1'b1, outputDriveOe_n);
        chk("neg word in reset", 16'hffff, sampleBitsNeg);
        chk("irq in reset", 1'b0, irq);
        rst <= 1'b0;
        waitCycles(4);
        rdChk("enable reset", ADDR_IRQ_ENABLE, 32'h7, 32'h0);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h5);
        rdChk("enable rw", ADDR_IRQ_ENABLE, 32'h7, 32'h5);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        rdChk("unmapped", 8'h20, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            outputModeStrap <= i[1:0];
            formatStrap <= i[1:0];
            waitCycles(8);
            rdChk("state", ADDR_STATE, 32'h1ff, {i==1||i==2, i>=2, 4'h1<<i});
            chk("oe_n mode", i < 2, outputDriveOe_n);
        end
        rdChk("strap event", ADDR_IRQ_STATUS, 32'h4, 32'h4);
        chk("irq masked", 1'b0, irq);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h4);
        waitCycles(2);
        chk("irq raised", 1'b1, irq);
        ahb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        waitCycles(2);
        chk("irq cleared", 1'b0, irq);
        rdChk("status cleared", ADDR_IRQ_STATUS, 32'h7, 32'h0);
        runStream(2'h3, 2'h0, 1'b0, 1'b0, 14);
        runStream(2'h3, 2'h3, 1'b0, 1'b1, 14);
        runStream(2'h2, 2'h2, 1'b1, 1'b0, 14);
        runStream(2'h2, 2'h1, 1'b1, 1'b1, 14);
        rdChk("over event", ADDR_IRQ_STATUS, 32'h1, 32'h1);
        // power-down, then the encode clock restarted for four rises
        powerDownPin <= 1'b1;
        waitCycles(8);
        chk("oe_n down", 1'b1, outputDriveOe_n);
        rdChk("pd state", ADDR_STATE, 32'h100, 32'h100);
        ahb(1'b0, ADDR_SAMPLE_COUNT, 32'h0);
        c = rd;
        runBase = encCount;
        encRun = 1'b1;
        wait (encCount == runBase + 4);
        encRun = 1'b0;
        waitCycles(20);
        rdChk("no conversion", ADDR_SAMPLE_COUNT, 32'hffffffff, c);
        powerDownPin <= 1'b0;
        waitCycles(8);
        chk("oe_n up", 1'b0, outputDriveOe_n);
        rdChk("wake event", ADDR_IRQ_STATUS, 32'h2, 32'h2);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
        waitCycles(2);
        chk("irq wake", 1'b1, irq);
        ahb(1'b1, ADDR_IRQ_CLEAR, 32'h2);
        waitCycles(2);
        chk("irq wake clear", 1'b0, irq);
        chk("leg errors", 0, legErrors);
        report_and_stop();
    end
endmodule
